/* sim/pin_partner.sv */
/*
 * Board model for the port pins: a weak external source on every pin and
 * the wired level that the device sees on its pin inputs.
 * Assumes the device drives a pin only while its output enable is high.
 */
`timescale 1ns/1ps
module pin_partner
    import port_cells_pkg::*;
(
    // device side
    input  wire port_byte_type pin_out_in,
    input  wire port_byte_type pin_oe_in,
    // board side
    input  wire port_byte_type ext_level_in,
    output port_byte_type      pin_level_out
);
    // ************************************************************
    // wired level
    // ************************************************************
    // an enabled device driver overrides the weak board source
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule // pin_partner

/* sim/tb.sv */
/*
 * Self-checking bench for the port pin input cells and port output logic.
 * Assumes the board model resolves pin levels and a 10 MHz clock_in.
 */
`timescale 1ns/1ps
module tb;
    import port_cells_pkg::*;
    // ************************************************************
    // stimulus and wiring
    // ************************************************************
    logic                 clock_in  = 1'b0;
    logic                 resetn_in = 1'b0;
    cpu_req_type          req       = '0;
    cell_mode_type [19:0] mode;
    logic [19:0]          alatch    = '0;
    port_byte_type        from_cell = '0, pt_oe = '0, ocell = '0, ext = '0;
    port_byte_type        pin_lvl, pout, poe;
    logic [5:0]           term      = '0;
    logic                 astb      = 1'b0, pdir = 1'b0;
    logic [15:0]          laddr     = 16'h0000;
    logic [7:0]           pdata     = 8'h00, rdata;
    logic [19:0]          cbus;
    int                   failures  = 0, n_checks = 0, cycles = 0;

    always #50 clock_in = ~clock_in;

    port_pin_input_cells #(.PORT_D_WIDTH(2)) port_pin_input_cells_i (
        .clock_in(clock_in), .resetn_in(resetn_in), .cpu_req_in(req),
        .cpu_rdata_out(rdata), .cell_mode_in(mode), .cell_addr_latch_in(alatch),
        .pin_from_cell_in(from_cell), .pt_oe_in(pt_oe), .cell_strobe_term_in(term),
        .addr_latch_strobe_in(astb), .latched_addr_in(laddr), .periph_data_in(pdata),
        .periph_dir_in(pdir), .output_cell_in(ocell), .pin_in(pin_lvl),
        .pin_out(pout), .pin_oe_out(poe), .cell_bus_out(cbus));

    pin_partner pin_partner_i (.pin_out_in(pout), .pin_oe_in(poe),
        .ext_level_in(ext), .pin_level_out(pin_lvl));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobes launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock_in);
        req = '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
        @(negedge clock_in);
        req = '0;
    endtask

    // read data is registered on the taking edge and checked at the next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock_in);
        req = '0;
        chk(rdata, exp);
    endtask

    // pins and terms pass a two-flop synchroniser, so allow margin
    task automatic settle;
        repeat (5) @(negedge clock_in);
    endtask

    task automatic pulse(input int k);
        term[k] = 1'b1;
        settle;
        term[k] = 1'b0;
        settle;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            finish_test;
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 20; i++) mode[i] = CELL_PASS;
        repeat (4) @(negedge clock_in);
        resetn_in = 1'b1;
        chk(poe.a, 8'h00);
        ext = '{a: 8'h5a, b: 8'hc3, c: 8'hff, d: 8'h06};
        settle;
        rd(OFF_CELLS_A, 8'h5a);
        rd(OFF_CELLS_B, 8'hc3);
        rd(OFF_CELLS_C, 8'h9c);
        chk({4'h0, cbus[19:16]}, 8'h0f);
        rd(OFF_DATA_IN_B, 8'hc3);
        wr(OFF_CELLS_A, 8'h00);
        rd(OFF_CELLS_A, 8'h5a);
        // register mode on port A, each nibble on its own term
        for (int i = 0; i < 8; i++) mode[i] = CELL_REG;
        pulse(0);
        pulse(1);
        ext.a = 8'ha5;
        settle;
        rd(OFF_CELLS_A, 8'h5a);
        pulse(0);
        rd(OFF_CELLS_A, 8'h55);
        pulse(1);
        rd(OFF_CELLS_A, 8'ha5);
        // latch mode on port B
        for (int i = 8; i < 16; i++) mode[i] = CELL_LATCH;
        term[3:2] = 2'b11;
        ext.b = 8'h3c;
        settle;
        rd(OFF_CELLS_B, 8'h3c);
        term[3:2] = 2'b00;
        settle;
        ext.b = 8'hf0;
        settle;
        rd(OFF_CELLS_B, 8'h3c);
        chk(cbus[15:8], 8'h3c);
        // address-latched cells on port C
        alatch[19:16] = 4'hf;
        astb = 1'b1;
        ext.c = 8'h04;
        settle;
        rd(OFF_CELLS_C, 8'h04);
        astb = 1'b0;
        settle;
        ext.c = 8'h98;
        settle;
        rd(OFF_CELLS_C, 8'h04);
        rd(OFF_DATA_IN_C, 8'h98);
        // port C register cells: C4 and C7 share the upper term, C2 and C3 keep
        alatch[19:16] = 4'h0;
        for (int i = 16; i < 20; i++) mode[i] = CELL_REG;
        pulse(5);
        rd(OFF_CELLS_C, 8'h94);
        // output enables, data out and readback
        pt_oe.a = 8'h30;
        ext.a = 8'h00;
        wr(OFF_DIR_A, 8'h0f);
        wr(OFF_DATA_OUT_A, 8'ha5);
        settle;
        chk(poe.a, 8'h3f);
        chk(pout.a, 8'ha5);
        rd(OFF_DIR_A, 8'h0f);
        rd(OFF_DATA_OUT_A, 8'ha5);
        rd(OFF_ENABLE_A, 8'h3f);
        pt_oe.a = 8'h00;
        settle;
        chk(poe.a, 8'h0f);
        rd(OFF_DATA_IN_A, 8'h05);
        from_cell.b = 8'hff;
        ocell.b = 8'h3c;
        settle;
        chk(pout.b, 8'h3c);
        chk(poe.b, 8'hff);
        laddr = 16'h7e81;
        wr(OFF_CONTROL_A, 8'hff);
        wr(OFF_CONTROL_B, 8'h0f);
        settle;
        chk(pout.a, 8'h81);
        chk(pout.b, 8'h3e);
        pdata = 8'h69;
        pdir = 1'b1;
        wr(OFF_PERIPH_MODE, 8'h80);
        settle;
        chk(pout.a, 8'h69);
        wr(OFF_DIR_D, 8'hff);
        rd(OFF_DIR_D, 8'h06);
        wr(OFF_DRIVE_C, 8'hff);
        rd(OFF_DRIVE_C, 8'h9c);
        rd(8'h30, 8'h00);
        // second reset in mid-run
        resetn_in = 1'b0;
        @(negedge clock_in);
        chk(pout.a, 8'h00);
        resetn_in = 1'b1;
        rd(OFF_DIR_A, RESET_BYTE);
        finish_test;
    end
endmodule // tb

/* verilog/port_cells_pkg.sv */
/*
 * Shared constants and carrier types for the port pin input cells and
 * per-pin port logic.
 * Assumes a single processor register page with 8-bit data and byte offsets.
 */
package port_cells_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFF_CELLS_A     = 8'h0a;
    localparam logic [7:0] OFF_CELLS_B     = 8'h0b;
    localparam logic [7:0] OFF_CELLS_C     = 8'h18;
    localparam logic [7:0] OFF_DATA_IN_A   = 8'h00;
    localparam logic [7:0] OFF_DATA_IN_B   = 8'h01;
    localparam logic [7:0] OFF_DATA_IN_C   = 8'h10;
    localparam logic [7:0] OFF_DATA_IN_D   = 8'h11;
    localparam logic [7:0] OFF_DATA_OUT_A  = 8'h04;
    localparam logic [7:0] OFF_DATA_OUT_B  = 8'h05;
    localparam logic [7:0] OFF_DATA_OUT_C  = 8'h12;
    localparam logic [7:0] OFF_DATA_OUT_D  = 8'h13;
    localparam logic [7:0] OFF_CONTROL_A   = 8'h02;
    localparam logic [7:0] OFF_CONTROL_B   = 8'h03;
    localparam logic [7:0] OFF_DIR_A       = 8'h06;
    localparam logic [7:0] OFF_DIR_B       = 8'h07;
    localparam logic [7:0] OFF_DIR_C       = 8'h14;
    localparam logic [7:0] OFF_DIR_D       = 8'h15;
    localparam logic [7:0] OFF_DRIVE_A     = 8'h08;
    localparam logic [7:0] OFF_DRIVE_B     = 8'h09;
    localparam logic [7:0] OFF_DRIVE_C     = 8'h16;
    localparam logic [7:0] OFF_DRIVE_D     = 8'h17;
    localparam logic [7:0] OFF_ENABLE_A    = 8'h0c;
    localparam logic [7:0] OFF_ENABLE_B    = 8'h0d;
    localparam logic [7:0] OFF_ENABLE_C    = 8'h1a;
    localparam logic [7:0] OFF_ENABLE_D    = 8'h1b;
    localparam logic [7:0] OFF_PERIPH_MODE = 8'h19;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         PERIPH_EN_BIT   = 7;
    localparam logic [7:0] PORT_C_CELL_MSK = 8'h9c;  // bits 7,4,3,2
    localparam logic [7:0] PORT_D_MSK      = 8'h06;  // bits 2,1
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef enum logic [2:0] {
        CELL_PASS  = 3'b001,
        CELL_LATCH = 3'b010,
        CELL_REG   = 3'b100
    } cell_mode_type;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } port_byte_type;

endpackage

/* verilog/port_pin_input_cells.sv */
/*
 * Input cells for ports A, B and C plus per-pin port output logic.
 * Assumes the logic array supplies cell strobe terms, output-enable terms
 * and output-cell data; the processor accesses the page with one-cycle
 * strobes on clock_in. Pins arrive asynchronously and are synchronised.
 */
`timescale 1ns/1ps

// Summary of operation
// RULE1: twenty input cells: all of ports A and B, four usable port C pins
// RULE2: each cell independently latches, registers or passes its pin
// RULE3: one strobe term per group of four cells, bits 0-3 and 4-7; port C terms take two cells each (C2-3, C4 and C7)
// RULE4: register mode samples on term rising edge; latch mode follows while high
// RULE5: latched-address cells use the address latch strobe as their gate
// RULE6: processor reads cell outputs at offsets 0ah, 0bh and 18h
// RULE7: each read bit shows the cell's present output level
// RULE8: port C cell bits 7,4,3,2 valid; test-access bits read zero
// RULE9: four ports: eight, eight, four, and two or one bits wide
// RULE10: output mux picks data-out, address, peripheral or output cell source
// RULE11: readback returns exactly one register source per processor read
// RULE12: output enable is product-term enable OR direction bit; ports A-C also OR in pin_from_cell_in; port A in peripheral mode takes periph_dir_in instead
// RULE13: with no other source, direction bit alone sets output enable
// RULE14: every pin feeds both port logic and its input cell; port D pins feed port logic only, with no cell
// RULE15: software must enable latched-address and peripheral modes at run time
// RULE16: processor I/O mode runs purely from run-time register writes
// RULE17: direction bit one drives pin out, zero leaves it input
// RULE18: pass-through cell shows pin level without an added stage
module port_pin_input_cells
    import port_cells_pkg::*;
#(
    parameter int PORT_D_WIDTH = 2
) (
    // clock and reset
    input  wire logic          clock_in,
    input  wire logic          resetn_in,
    // processor register page
    input  wire cpu_req_type   cpu_req_in,
    output logic [7:0]         cpu_rdata_out,
    // programmed configuration
    input  wire cell_mode_type [19:0] cell_mode_in,
    input  wire logic [19:0]   cell_addr_latch_in,
    input  wire port_byte_type pin_from_cell_in,
    input  wire port_byte_type pt_oe_in,
    // logic array terms and sources
    input  wire logic [5:0]    cell_strobe_term_in,
    input  wire logic          addr_latch_strobe_in,
    input  wire logic [15:0]   latched_addr_in,
    input  wire logic [7:0]    periph_data_in,
    input  wire logic          periph_dir_in,
    input  wire port_byte_type output_cell_in,
    // pins
    input  wire port_byte_type pin_in,
    output port_byte_type      pin_out,
    output port_byte_type      pin_oe_out,
    // logic array input bus
    output logic [19:0]        cell_bus_out
);

    // ************************************************************
    // synchronisers and cell state
    // ************************************************************
    port_byte_type pin_meta_reg, pin_sync_reg;
    logic [5:0]    strobe_meta_reg, strobe_sync_reg, strobe_prev_reg;
    logic          ale_meta_reg, ale_sync_reg;
    logic [19:0]   cell_hold_reg;
    logic [19:0]   cell_pin;
    logic [19:0]   cell_value;
    logic [19:0]   cell_next;

    // two stages for the pins, the cell strobe terms and the address latch strobe
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_meta_reg    <= '0;
            pin_sync_reg    <= '0;
            strobe_meta_reg <= '0;
            strobe_sync_reg <= '0;
            strobe_prev_reg <= '0;
            ale_meta_reg    <= 1'b0;
            ale_sync_reg    <= 1'b0;
        end else begin
            pin_meta_reg    <= pin_in;
            pin_sync_reg    <= pin_meta_reg;
            strobe_meta_reg <= cell_strobe_term_in;
            strobe_sync_reg <= strobe_meta_reg;
            strobe_prev_reg <= strobe_sync_reg;
            ale_meta_reg    <= addr_latch_strobe_in;
            ale_sync_reg    <= ale_meta_reg;
        end
    end

    // the same synchronised pin feeds port logic and the cells [RULE14]
    assign cell_pin = {pin_sync_reg.c[7], pin_sync_reg.c[4:2],
                       pin_sync_reg.b, pin_sync_reg.a};  // [RULE1]

    // strobe group index: A0-3,A4-7,B0-3,B4-7,C2-3,C4 and C7 [RULE3]
    // port C follows the same split by bit number, so C4 rides the upper term
    function automatic int group_of(input int idx);
        if (idx < 16) begin
            group_of = idx / 4;
        end else begin
            group_of = (idx >= 18) ? 5 : 4;
        end
    endfunction

    // per-cell next value; cell output is combinational in pass mode
    always_comb begin
        cell_next  = cell_hold_reg;
        cell_value = cell_hold_reg;
        for (int i = 0; i < 20; i++) begin
            if (cell_addr_latch_in[i]) begin
                if (ale_sync_reg) begin  // [RULE5]
                    cell_next[i] = cell_pin[i];
                end
                cell_value[i] = ale_sync_reg ? cell_pin[i] : cell_hold_reg[i];
            end else begin
                case (cell_mode_in[i])  // [RULE2]
                    CELL_PASS: begin
                        cell_next[i]  = cell_pin[i];
                        cell_value[i] = cell_pin[i];  // [RULE18]
                    end
                    CELL_LATCH: begin
                        if (strobe_sync_reg[group_of(i)]) begin  // [RULE4]
                            cell_next[i] = cell_pin[i];
                        end
                        cell_value[i] = strobe_sync_reg[group_of(i)] ?
                                        cell_pin[i] : cell_hold_reg[i];
                    end
                    CELL_REG: begin
                        if (strobe_sync_reg[group_of(i)] &&
                            !strobe_prev_reg[group_of(i)]) begin  // [RULE4]
                            cell_next[i] = cell_pin[i];
                        end
                    end
                    default: begin
                        cell_value[i] = cell_pin[i];
                    end
                endcase
            end
        end
    end

    // hold state for latch and register cells
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cell_hold_reg <= '0;
        end else begin
            cell_hold_reg <= cell_next;
        end
    end

    // ************************************************************
    // port registers
    // ************************************************************
    port_byte_type data_out_reg, dir_reg, drive_reg;
    logic [7:0]    control_a_reg, control_b_reg;
    logic          periph_en_reg;
    logic [7:0]    width_d;

    assign width_d = (PORT_D_WIDTH == 1) ? 8'h02 : PORT_D_MSK;  // [RULE9]

    // processor writes are the only thing steering processor I/O [RULE16]
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_out_reg  <= '0;
            dir_reg       <= '0;
            drive_reg     <= '0;
            control_a_reg <= RESET_BYTE;
            control_b_reg <= RESET_BYTE;
            periph_en_reg <= 1'b0;
        end else if (cpu_req_in.write) begin
            case (cpu_req_in.addr)
                OFF_DATA_OUT_A:  data_out_reg.a <= cpu_req_in.wdata;
                OFF_DATA_OUT_B:  data_out_reg.b <= cpu_req_in.wdata;
                OFF_DATA_OUT_C:  data_out_reg.c <= cpu_req_in.wdata & PORT_C_CELL_MSK;
                OFF_DATA_OUT_D:  data_out_reg.d <= cpu_req_in.wdata & width_d;
                OFF_DIR_A:       dir_reg.a <= cpu_req_in.wdata;
                OFF_DIR_B:       dir_reg.b <= cpu_req_in.wdata;
                OFF_DIR_C:       dir_reg.c <= cpu_req_in.wdata & PORT_C_CELL_MSK;
                OFF_DIR_D:       dir_reg.d <= cpu_req_in.wdata & width_d;
                OFF_DRIVE_A:     drive_reg.a <= cpu_req_in.wdata;
                OFF_DRIVE_B:     drive_reg.b <= cpu_req_in.wdata;
                OFF_DRIVE_C:     drive_reg.c <= cpu_req_in.wdata & PORT_C_CELL_MSK;
                OFF_DRIVE_D:     drive_reg.d <= cpu_req_in.wdata & width_d;
                OFF_CONTROL_A:   control_a_reg <= cpu_req_in.wdata;
                OFF_CONTROL_B:   control_b_reg <= cpu_req_in.wdata;
                OFF_PERIPH_MODE: periph_en_reg <= cpu_req_in.wdata[PERIPH_EN_BIT];
                default:         periph_en_reg <= periph_en_reg;
            endcase
        end
    end

    // ************************************************************
    // output mux and enables
    // ************************************************************
    port_byte_type mux_value, oe_value;
    logic          periph_on;

    // peripheral mode is set by the run-time enable alone, with no separate selection [RULE15]
    assign periph_on = periph_en_reg;

    // priority: peripheral, address, output cell, data-out [RULE10]
    assign mux_value.a = periph_on ? periph_data_in :
                         (control_a_reg & latched_addr_in[7:0]) |
                         (~control_a_reg & pin_from_cell_in.a & output_cell_in.a) |
                         (~control_a_reg & ~pin_from_cell_in.a & data_out_reg.a);
    assign mux_value.b = (control_b_reg & latched_addr_in[15:8]) |
                         (~control_b_reg & pin_from_cell_in.b & output_cell_in.b) |
                         (~control_b_reg & ~pin_from_cell_in.b & data_out_reg.b);
    assign mux_value.c = ((pin_from_cell_in.c & output_cell_in.c) |
                          (~pin_from_cell_in.c & data_out_reg.c)) & PORT_C_CELL_MSK;
    assign mux_value.d = data_out_reg.d & width_d;

    // enable is term OR direction OR output-cell select (D: term OR direction; periph_on A: periph_dir_in); direction alone if others low [RULE12] [RULE13]
    assign oe_value.a = periph_on ? {8{periph_dir_in}} :
                        (pt_oe_in.a | dir_reg.a | pin_from_cell_in.a);  // [RULE17]
    assign oe_value.b = pt_oe_in.b | dir_reg.b | pin_from_cell_in.b;
    assign oe_value.c = (pt_oe_in.c | dir_reg.c | pin_from_cell_in.c) & PORT_C_CELL_MSK;
    assign oe_value.d = (pt_oe_in.d | dir_reg.d) & width_d;

    // registered pin drive
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_out    <= '0;
            pin_oe_out <= '0;
        end else begin
            pin_out    <= mux_value;
            pin_oe_out <= oe_value;
        end
    end

    // ************************************************************
    // readback buffer: one source per read
    // ************************************************************
    logic [7:0] rd_value;

    // unmapped offsets read zero [RULE11] [RULE6] [RULE7]
    assign rd_value =
        (cpu_req_in.addr == OFF_CELLS_A)    ? cell_value[7:0] :
        (cpu_req_in.addr == OFF_CELLS_B)    ? cell_value[15:8] :
        (cpu_req_in.addr == OFF_CELLS_C)    ? {cell_value[19], 2'b00,
                                               cell_value[18:16], 2'b00} :  // [RULE8]
        (cpu_req_in.addr == OFF_DATA_IN_A)  ? pin_sync_reg.a :
        (cpu_req_in.addr == OFF_DATA_IN_B)  ? pin_sync_reg.b :
        (cpu_req_in.addr == OFF_DATA_IN_C)  ? pin_sync_reg.c & PORT_C_CELL_MSK :
        (cpu_req_in.addr == OFF_DATA_IN_D)  ? pin_sync_reg.d & width_d :
        (cpu_req_in.addr == OFF_DATA_OUT_A) ? data_out_reg.a :
        (cpu_req_in.addr == OFF_DATA_OUT_B) ? data_out_reg.b :
        (cpu_req_in.addr == OFF_DATA_OUT_C) ? data_out_reg.c :
        (cpu_req_in.addr == OFF_DATA_OUT_D) ? data_out_reg.d :
        (cpu_req_in.addr == OFF_DIR_A)      ? dir_reg.a :
        (cpu_req_in.addr == OFF_DIR_B)      ? dir_reg.b :
        (cpu_req_in.addr == OFF_DIR_C)      ? dir_reg.c :
        (cpu_req_in.addr == OFF_DIR_D)      ? dir_reg.d :
        (cpu_req_in.addr == OFF_DRIVE_A)    ? drive_reg.a :
        (cpu_req_in.addr == OFF_DRIVE_B)    ? drive_reg.b :
        (cpu_req_in.addr == OFF_DRIVE_C)    ? drive_reg.c :
        (cpu_req_in.addr == OFF_DRIVE_D)    ? drive_reg.d :
        (cpu_req_in.addr == OFF_CONTROL_A)  ? control_a_reg :
        (cpu_req_in.addr == OFF_CONTROL_B)  ? control_b_reg :
        (cpu_req_in.addr == OFF_ENABLE_A)   ? pin_oe_out.a :
        (cpu_req_in.addr == OFF_ENABLE_B)   ? pin_oe_out.b :
        (cpu_req_in.addr == OFF_ENABLE_C)   ? pin_oe_out.c :
        (cpu_req_in.addr == OFF_ENABLE_D)   ? pin_oe_out.d :
        (cpu_req_in.addr == OFF_PERIPH_MODE) ? {periph_en_reg, 7'h00} : 8'h00;

    // read data and cell bus registered so outputs come from flops
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_rdata_out <= 8'h00;
            cell_bus_out  <= '0;
        end else begin
            cpu_rdata_out <= cpu_req_in.read ? rd_value : 8'h00;
            cell_bus_out  <= cell_value;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_CELL_C_GAPS: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE8]
        (cpu_req_in.read && cpu_req_in.addr == OFF_CELLS_C) |=> (cpu_rdata_out & 8'h63) == 8'h00)
        else $error("port C cell gap bits not zero");
    AST_PASS_FOLLOWS: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE18]
        (cell_mode_in[0] == CELL_PASS && !cell_addr_latch_in[0]) |=>
        cell_bus_out[0] == $past(cell_pin[0]))
        else $error("pass cell not following pin");
    AST_REG_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE4]
        (cell_mode_in[0] == CELL_REG && !cell_addr_latch_in[0] &&
         !(strobe_sync_reg[0] && !strobe_prev_reg[0])) |=> $stable(cell_hold_reg[0]))
        else $error("register cell changed without edge");
    AST_LATCH_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE4]
        (cell_mode_in[12] == CELL_LATCH && !cell_addr_latch_in[12] && !strobe_sync_reg[3])
        |=> $stable(cell_hold_reg[12]))
        else $error("latch cell changed while gate low");
    AST_ALE_CAPTURE: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE5]
        (cell_addr_latch_in[16] && ale_sync_reg) |=> cell_hold_reg[16] == $past(cell_pin[16]))
        else $error("address latch cell missed capture");
    AST_OE_DIR: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE12]
        (!periph_en_reg && dir_reg.a[0]) |=> pin_oe_out.a[0])
        else $error("direction bit did not enable output");
    AST_OE_OFF: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE13]
        (!dir_reg.b[3] && !pt_oe_in.b[3] && !pin_from_cell_in.b[3]) |=> !pin_oe_out.b[3])
        else $error("output enabled with no source");
    AST_DOUT_READ: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE11]
        (cpu_req_in.read && cpu_req_in.addr == OFF_DATA_OUT_A) |=>
        cpu_rdata_out == $past(data_out_reg.a))
        else $error("data-out readback wrong");
    AST_MCU_DRIVE: assert property (@(posedge clock_in) disable iff (!resetn_in)  // [RULE10]
        (!periph_en_reg && !control_a_reg[2] && !pin_from_cell_in.a[2]) |=>
        pin_out.a[2] == $past(data_out_reg.a[2]))
        else $error("data-out not driven on pin");

    COV_REG_EDGE: cover property (@(posedge clock_in) strobe_sync_reg[0] && !strobe_prev_reg[0]);
    COV_ALE: cover property (@(posedge clock_in) ale_sync_reg && cell_addr_latch_in[16]);
    COV_PERIPH: cover property (@(posedge clock_in) periph_en_reg);
    COV_CELL_READ: cover property (@(posedge clock_in) cpu_req_in.read &&
                                   cpu_req_in.addr == OFF_CELLS_A);

endmodule // port_pin_input_cells
